// ==== hdl/asi_core.sv ====
// Control and serial interface of a sampling converter.
// Assumes host pins arrive asynchronously and the analog core hands
// over both results on mclk by the end of each conversion.
`timescale 1ns/10ps

module asi_core (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rst_b,
  // Host serial pins
  input  wire logic                      cs_b,
  input  wire logic                      sck,
  input  wire logic                      cfg_in,
  input  wire logic                      convert_strobe,
  input  wire logic                      reset_in,
  input  wire logic                      power_down_in,
  // Analog core results, on mclk
  input  wire logic [asi_pkg::RES_W-1:0] core_result_a,
  input  wire logic [asi_pkg::RES_W-1:0] core_result_b,
  // Serial outputs
  output logic                           result_serial_out,
  output logic                           busy_or_second_result_out,
  // Core control and status
  output logic                           conv_start,
  output logic                           powered_down,
  output logic      [asi_pkg::CFG_W-1:0] active_cfg
);
  import asi_pkg::*;

  // ****************************************************************
  // Pin synchronisation and edge detection
  // ****************************************************************
  logic [5:0] pins_s;   // Synchronised pins.
  logic [5:0] pins_q;   // One cycle older copy for edge detection.

  asi_sync #(.WIDTH(6)) u_sync (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .pins   ({cs_b, sck, cfg_in, convert_strobe, reset_in,
              power_down_in}),
    .pins_s (pins_s)
  );

  // The old copy feeds only the edge detectors below. It resets to the
  // same value as the synchroniser, so no false edge follows reset.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pins_q <= 6'h00;
    end else begin
      pins_q <= pins_s;
    end
  end

  wire cs_act   = ~pins_s[5];                  // Select asserted.
  wire cs_fall  = ~pins_s[5] & pins_q[5];      // Select just taken.
  wire sck_rise = pins_s[4] & ~pins_q[4];      // Serial clock rose.
  wire sck_fall = ~pins_s[4] & pins_q[4];      // Serial clock fell.
  wire din_s    = pins_s[3];                   // Configuration bit.
  wire cnv_rise = pins_s[2] & ~pins_q[2];      // Convert strobe rose.
  wire rst_rise = pins_s[1] & ~pins_q[1];      // Reset pin rose.
  wire pd_s     = pins_s[0];                   // Power-down level.
  wire pd_rise  = pins_s[0] & ~pins_q[0];      // Power-down rose.

  // ****************************************************************
  // Conversion state machine
  // ****************************************************************
  asi_state_t state;        // Present state.
  asi_state_t next_state;   // State after this edge.
  logic [CNT_W-1:0] conv_cnt;  // Cycles left in the conversion.

  wire eoc       = (state == ST_CONV) && (conv_cnt == 10'h001);
  wire start     = (state == ST_IDLE) && (next_state == ST_CONV);
  wire next_busy = (next_state == ST_CONV);

  // The reset pin edge is caught through the synchroniser, so its
  // effect lands three edges late; that keeps every flop on one clock.
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (pd_rise) begin
          next_state = ST_PDN;
        end else if (cnv_rise) begin
          next_state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (pd_rise) begin
          next_state = ST_PDN;
        end else if (eoc) begin
          next_state = ST_IDLE;
        end
      end
      ST_PDN: begin
        if (!pd_s) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (rst_rise) begin
      next_state = ST_IDLE;
    end
  end

  // State register and conversion timer.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state    <= ST_IDLE;
      conv_cnt <= '0;
    end else begin
      state    <= next_state;
      conv_cnt <= start ? CONV_CYCLES :
                  (state == ST_CONV) ? conv_cnt - 10'h001 : '0;
    end
  end

  // ****************************************************************
  // Configuration capture
  // ****************************************************************
  logic [CAP_W-1:0] cap_cnt;      // Bits taken since last conversion.
  logic             cfg_pending;  // A whole new word is waiting.
  logic [CFG_W-1:0] cfg_shadow;   // Word being shifted in.
  logic [CFG_W-1:0] conv_cfg;     // Configuration used by conversion.

  // Capture is closed while converting; writes then would only add
  // noise, so the host is expected to stay quiet anyway.
  wire cap_shift = sck_rise && cs_act && (state == ST_IDLE)
                   && (cap_cnt <= {1'b0, CAP_LAST[3:0]});

  asi_shift #(.WIDTH(CFG_W)) u_cfg_shift (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .load     (rst_rise),
    .load_val (CFG_RESET),
    .shift    (cap_shift),
    .shift_in (din_s),
    .value    (cfg_shadow)
  );

  // Counter reopens at each end of conversion; pending drops when used.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cap_cnt     <= '0;
      cfg_pending <= 1'b0;
    end else if (rst_rise || eoc) begin
      cap_cnt     <= '0;
      cfg_pending <= 1'b0;
    end else if (cap_shift) begin
      cap_cnt     <= cap_cnt + 5'h01;
      cfg_pending <= cfg_pending | (cap_cnt == CAP_LAST);
    end
  end

  // Active word changes only at end of conversion or reset.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      active_cfg <= CFG_RESET;
      conv_cfg   <= CFG_RESET;
    end else if (rst_rise) begin
      active_cfg <= CFG_RESET;
      conv_cfg   <= CFG_RESET;
    end else begin
      if (eoc && cfg_pending) begin
        active_cfg <= cfg_shadow;
      end
      if (start) begin
        conv_cfg <= active_cfg;
      end
    end
  end

  // ****************************************************************
  // Result shifting
  // ****************************************************************
  logic [OUT_W-1:0] out_sr;    // Result then configuration readback.
  logic [RES_W-1:0] out2_sr;   // Second channel result.
  logic             second_result_out_sel;  // Second output chosen at select.

  wire out_shift = sck_fall && cs_act && (state == ST_IDLE);

  asi_shift #(.WIDTH(OUT_W)) u_out_shift (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .load     (eoc),
    .load_val ({core_result_a, conv_cfg}),
    .shift    (out_shift),
    .shift_in (1'b0),
    .value    (out_sr)
  );

  asi_shift #(.WIDTH(RES_W)) u_out2_shift (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .load     (eoc),
    .load_val (core_result_b),
    .shift    (out_shift),
    .shift_in (1'b0),
    .value    (out2_sr)
  );

  // The second output mode is frozen when select falls, so a word
  // loaded mid-frame cannot switch the pin under the host.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      second_result_out_sel <= 1'b0;
    end else if (cs_fall) begin
      second_result_out_sel <= active_cfg[CFG_SECOND_RESULT_OUT_BIT];
    end
  end

  // ****************************************************************
  // Output registers
  // ****************************************************************
  wire data2_on = cs_act && second_result_out_sel && !next_busy;

  // Busy, start and power-down outputs are registered from next-state terms, so busy falls on
  // the same edge that loads the active configuration.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      result_serial_out         <= 1'b0;
      busy_or_second_result_out <= 1'b0;
      conv_start                <= 1'b0;
      powered_down              <= 1'b0;
    end else begin
      result_serial_out         <= cs_act & out_sr[OUT_W-1];
      busy_or_second_result_out <= data2_on ? out2_sr[RES_W-1]
                                            : next_busy;
      conv_start                <= start;
      powered_down              <= (next_state == ST_PDN);
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_shift_held;
    out_shift && !rst_rise ##1 cs_act;
  endsequence

  select_gate_a: assert property (
    !cs_act |=> !result_serial_out)
    else $error("serial output active with select high");

  cfg_sample_a: assert property (
    cap_shift && !rst_rise |=> cfg_shadow[0] == $past(din_s))
    else $error("configuration bit not sampled");

  cfg_apply_a: assert property (
    $changed(active_cfg) && !$past(rst_rise) |->
      $past(state) == ST_CONV && state == ST_IDLE)
    else $error("configuration changed outside end of conversion");

  cap_limit_a: assert property (
    cap_shift && cap_cnt == CAP_LAST && !rst_rise |=>
      cfg_pending ##1 !cap_shift || cap_cnt == 5'h10)
    else $error("capture did not close after sixteen bits");

  reset_abort_a: assert property (
    rst_rise |=> state == ST_IDLE && active_cfg == CFG_RESET)
    else $error("reset edge did not abort");

  pd_hold_a: assert property (
    pd_rise && !rst_rise |=> powered_down && state == ST_PDN)
    else $error("power-down edge ignored");

  result_shift_a: assert property (
    s_shift_held |=> result_serial_out == $past(out_sr[OUT_W-2], 2))
    else $error("result bit not advanced on falling clock");

  busy_pin_a: assert property (
    !cs_act |=> busy_or_second_result_out == $past(next_busy))
    else $error("shared pin not showing busy");

  conv_len_a: assert property (
    cnv_rise && state == ST_IDLE && !pd_rise && !rst_rise |=>
      conv_start ##0 (state == ST_CONV)[*8])
    else $error("conversion did not start and run");

endmodule : asi_core

// ==== inc/asi_pkg.sv ====
// Shared constants for the converter serial interface block.
// Assumes a 250 MHz core clock; every host pin is synchronised first.
package asi_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int CFG_W = 16;             // Configuration word width.
  localparam int RES_W = 16;             // Conversion result width.
  localparam int OUT_W = RES_W + CFG_W;  // Result then readback.
  localparam int CNT_W = 10;             // Conversion counter width.
  localparam int CAP_W = 5;              // Capture bit counter width.

  // ****************************************************************
  // Configuration fields and reset value
  // ****************************************************************
  localparam int          CFG_SECOND_RESULT_OUT_BIT = 0;        // Second output on.
  localparam logic [15:0] CFG_RESET    = 16'h0000; // Default contents.
  localparam logic [4:0]  CAP_LAST     = 5'h0f;    // Last captured bit.

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 4;      // Core clock period.
  localparam int CONV_TIME_NS  = 1600;   // Least conversion time.
  localparam logic [9:0] CONV_CYCLES =
    10'((CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ****************************************************************
  // State machine
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,  // Waiting, serial port open.
    ST_CONV = 2'b01,  // Conversion running, converter busy.
    ST_PDN  = 2'b10   // Powered down.
  } asi_state_t;

endpackage : asi_pkg

// ==== hdl/asi_sync.sv ====
// Two flip-flop synchroniser for a group of single-bit pins.
// Assumes each bit is an independent level from outside mclk.
`timescale 1ns/10ps

module asi_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_b,
  // Pins and their synchronised copies
  input  wire logic [WIDTH-1:0] pins,
  output logic      [WIDTH-1:0] pins_s
);

  logic [WIDTH-1:0] meta;  // First stage, read only by the second.

  // Both stages clear at reset so no stale pin level survives it.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta   <= '0;
      pins_s <= '0;
    end else begin
      meta   <= pins;
      pins_s <= meta;
    end
  end

endmodule : asi_sync

// ==== hdl/asi_shift.sv ====
// Loadable left shift register, most significant bit leaves first.
// Assumes load and shift never need to act in the same cycle.
`timescale 1ns/10ps

module asi_shift #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_b,
  // Control
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_val,
  input  wire logic             shift,
  input  wire logic             shift_in,
  // Contents
  output logic      [WIDTH-1:0] value
);

  // Load has priority, since a fresh result must never be shifted away.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      value <= '0;
    end else if (load) begin
      value <= load_val;
    end else if (shift) begin
      value <= {value[WIDTH-2:0], shift_in};
    end
  end

endmodule : asi_shift

// ==== tb/asi_host.sv ====
// Host controller model that drives the serial pins of the block.
// Assumes the bench calls its tasks at falling edges of mclk.
`timescale 1ns/10ps

module asi_host (
  // Clock
  input  wire logic mclk,
  // Pins toward the block
  output logic      cs_b,
  output logic      sck,
  output logic      cfg_in,
  output logic      convert_strobe,
  output logic      reset_in,
  output logic      power_down_in,
  // Pins from the block
  input  wire logic result_serial_out,
  input  wire logic busy_or_second_result_out
);
  localparam int HALF = 4;  // Half of the 32 ns serial clock period.
  localparam int HOLD = 25; // Reset stays low 100 ns after wake-up.
  localparam int WAKE = 50; // Shortened reference wake-up wait.

  // All pins idle; the serial clock rests low, and moves between frames only when the bench wiggles it.
  initial begin
    cs_b           = 1'b1;
    sck            = 1'b0;
    cfg_in         = 1'b0;
    convert_strobe = 1'b0;
    reset_in       = 1'b0;
    power_down_in  = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick

  // A short high pulse; its rising edge starts a conversion.
  task automatic start_conv();
    convert_strobe = 1'b1;
    tick(2);
    convert_strobe = 1'b0;
  endtask : start_conv

  // One frame: 16 configuration bits and 32 output bits, MSB first.
  // Each output bit is taken just before the fall that advances it.
  task automatic xfer(input logic [15:0] cfg, output logic [31:0] w1,
                      output logic [31:0] w2);
    cs_b = 1'b0;
    for (int i = 0; i < 32; i++) begin
      cfg_in = (i < 16) ? cfg[15-i] : ~cfg_in;
      tick(HALF);
      sck = 1'b1;
      tick(HALF);
      w1[31-i] = result_serial_out;
      w2[31-i] = busy_or_second_result_out;
      sck = 1'b0;
    end
    tick(HALF);
    cs_b   = 1'b1;
    cfg_in = ~cfg_in; // A released line does not keep its last value.
  endtask : xfer

  task automatic pulse_reset();
    reset_in = 1'b1;
    tick(2);
    reset_in = 1'b0;
  endtask : pulse_reset

  // Sleep, then wake keeping reset low before any use of the block.
  task automatic pd_enter();
    power_down_in = 1'b1;
  endtask : pd_enter

  task automatic pd_exit();
    power_down_in = 1'b0;
    reset_in      = 1'b0;
    tick(HOLD);
    tick(WAKE);
  endtask : pd_exit
endmodule : asi_host

// ==== tb/asi_core_tb.sv ====
// Self-checking bench for the converter serial interface core.
// Assumes the host model drives every host pin on falling mclk edges.
`timescale 1ns/10ps

module asi_core_tb;
  import asi_pkg::*;
  logic             mclk, rst_b, cs_b, sck, cfg_in, convert_strobe;
  logic             reset_in, power_down_in, conv_start, powered_down;
  logic [RES_W-1:0] core_result_a, core_result_b;
  logic             result_serial_out, busy_or_second_result_out;
  logic [CFG_W-1:0] active_cfg;
  int               err_count, comparisons, starts;

  asi_core dut_u (.mclk(mclk), .rst_b(rst_b), .cs_b(cs_b), .sck(sck),
    .cfg_in(cfg_in), .convert_strobe(convert_strobe), .reset_in(reset_in),
    .power_down_in(power_down_in), .core_result_a(core_result_a),
    .core_result_b(core_result_b), .result_serial_out(result_serial_out),
    .busy_or_second_result_out(busy_or_second_result_out),
    .conv_start(conv_start), .powered_down(powered_down),
    .active_cfg(active_cfg));
  asi_host host_u (.mclk(mclk), .cs_b(cs_b), .sck(sck), .cfg_in(cfg_in),
    .convert_strobe(convert_strobe), .reset_in(reset_in),
    .power_down_in(power_down_in), .result_serial_out(result_serial_out),
    .busy_or_second_result_out(busy_or_second_result_out));

  // 250 MHz core clock.
  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  // Counts conversion start pulses so ignored strobes can be seen.
  always @(posedge mclk) if (conv_start === 1'b1) starts <= starts + 1;

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic complete_run();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // One conversion; a second strobe mid-way must be ignored.
  task automatic convert(input logic [15:0] a, b, old_cfg, new_cfg);
    int          n;
    int          s0;
    logic [15:0] prev;
    n = 0;
    s0 = starts;
    prev = active_cfg;
    core_result_a = a;
    core_result_b = b;
    host_u.start_conv();
    for (int k = 0; k < 1000; k++) begin
      if (busy_or_second_result_out === 1'b1) n++;
      else if (n > 0) break;
      if (n == 100) host_u.convert_strobe = 1'b1;
      if (n == 102) host_u.convert_strobe = 1'b0;
      prev = active_cfg;
      @(negedge mclk);
    end
    chk("busy cycles", CONV_CYCLES, n);
    chk("start pulses", 1, starts - s0);
    chk("cfg before end", old_cfg, prev);
    chk("cfg at end", new_cfg, active_cfg);
  endtask : convert

  // Convert, wiggle the clock while deselected, then read one frame.
  task automatic cycle(input logic [15:0] a, b, send, old_cfg, new_cfg,
                       rb, input logic en2);
    logic [31:0] w1, w2;
    convert(a, b, old_cfg, new_cfg);
    repeat (2) begin
      host_u.sck = 1'b1;
      host_u.tick(4);
      host_u.sck = 1'b0;
      host_u.tick(4);
    end
    chk("out deselected", 0, result_serial_out);
    host_u.xfer(send, w1, w2);
    chk("main word", {a, rb}, w1);
    chk("second word", en2 ? {b, 16'h0000} : 32'h0, w2);
    chk("cfg after write", new_cfg, active_cfg);
  endtask : cycle

  // Abort in mid-conversion restores the default configuration.
  task automatic reset_abort();
    host_u.start_conv();
    host_u.tick(50);
    host_u.pulse_reset();
    host_u.tick(8);
    chk("busy after reset", 0, busy_or_second_result_out);
    chk("cfg after reset", CFG_RESET, active_cfg);
  endtask : reset_abort

  // Power-down ignores strobes; wake-up then needs a dummy conversion.
  task automatic power_cycle();
    int s0;
    host_u.pd_enter();
    host_u.tick(8);
    chk("asleep", 1, powered_down);
    s0 = starts;
    host_u.start_conv();
    host_u.tick(10);
    chk("strobe asleep", s0, starts);
    host_u.pd_exit();
    chk("awake", 0, powered_down);
    cycle(16'h0f0f, 16'hf0f0, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
          1'b0);
  endtask : power_cycle

  // Main sequence.
  initial begin
    rst_b = 1'b0;
    err_count = 0;
    comparisons = 0;
    starts = 0;
    core_result_a = 16'h0000;
    core_result_b = 16'h0000;
    repeat (20) @(negedge mclk);
    rst_b = 1'b1;
    @(negedge mclk);
    chk("cfg at reset", CFG_RESET, active_cfg);
    chk("outputs at reset", 0, {result_serial_out, conv_start,
        busy_or_second_result_out, powered_down});
    cycle(16'h8001, 16'h7ffe, 16'ha5c3, 16'h0000, 16'h0000, 16'h0000,
          1'b0);
    cycle(16'h1234, 16'hfedc, 16'h3c5b, 16'h0000, 16'ha5c3, 16'h0000,
          1'b1);
    cycle(16'hffff, 16'h8000, 16'h0000, 16'ha5c3, 16'h3c5b, 16'ha5c3,
          1'b1);
    reset_abort();
    power_cycle();
    complete_run();
  end

  // Watchdog: the sequence needs well under 10000 cycles.
  initial begin
    repeat (60000) @(posedge mclk);
    err_count++;
    complete_run();
  end
endmodule : asi_core_tb
